// File: sdp_pkg.sv
// constants, field layouts and carrier types for the short-circuit discharge protection block
// assumes a 100 MHz hclk and a single AHB-Lite master
package sdp_pkg;
	// timebase
	localparam int CLK_NS   = 10;
	localparam int STEP_NS  = 15000;                          // 15 us delay step
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS; // least time, rounded up
	localparam int DLY_MAX  = 30;                             // 450 us / 15 us

	// register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_TIME  = 8'h04;
	localparam logic [7:0] OFF_LATCH = 8'h08;
	localparam logic [7:0] OFF_LREC  = 8'h0c;
	localparam logic [7:0] OFF_CMD   = 8'h10;
	localparam logic [7:0] OFF_STAT  = 8'h14;

	// control register fields
	localparam int B_SCD_EN   = 0;
	localparam int B_LATCH_EN = 1;
	localparam int B_AUTO     = 2;
	localparam int B_CHG_CFG  = 3;
	localparam int B_CUR_REC  = 4;
	localparam int B_LD_EN    = 5;
	localparam int B_SERIES   = 6;
	localparam int F_THR      = 8;   // 4 bits
	localparam int F_DLY      = 16;  // 5 bits

	// status register fields
	localparam int S_ALERT   = 0;
	localparam int S_FAULT   = 1;
	localparam int S_LALERT  = 2;
	localparam int S_PFALERT = 3;
	localparam int S_LFAULT  = 4;
	localparam int S_PF      = 5;
	localparam int S_DSG     = 6;
	localparam int S_CHG     = 7;
	localparam int S_LREC    = 12;
	localparam int F_CNT     = 8;   // 4 bits
	localparam int F_LEVEL   = 16;  // 10 bits, selected threshold in mV

	// reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] TIME_RST  = 32'h0010_0010;
	localparam logic [31:0] LATCH_RST = 32'h0100_0003;
	localparam logic [31:0] LREC_RST  = 32'h0010_0000;
	localparam logic [15:0] CMD_LATCH_RECOVER = 16'h009c;
	localparam logic [3:0]  CNT_MAX   = 4'hf;

	// synchronised pin group
	typedef struct packed {
		logic [9:0]  sense_mv;
		logic [15:0] current;
		logic        load_removed;
		logic        charge_switch;
	} sdp_pins_t;

	// threshold index to mV, ascending
	function automatic logic [9:0] sdp_thr_mv(input logic [3:0] idx);
		case (idx)
			4'h0: sdp_thr_mv = 10'd10;
			4'h1: sdp_thr_mv = 10'd20;
			4'h2: sdp_thr_mv = 10'd40;
			4'h3: sdp_thr_mv = 10'd60;
			4'h4: sdp_thr_mv = 10'd80;
			4'h5: sdp_thr_mv = 10'd100;
			4'h6: sdp_thr_mv = 10'd125;
			4'h7: sdp_thr_mv = 10'd150;
			4'h8: sdp_thr_mv = 10'd175;
			4'h9: sdp_thr_mv = 10'd200;
			4'ha: sdp_thr_mv = 10'd250;
			4'hb: sdp_thr_mv = 10'd300;
			4'hc: sdp_thr_mv = 10'd350;
			4'hd: sdp_thr_mv = 10'd400;
			4'he: sdp_thr_mv = 10'd450;
			default: sdp_thr_mv = 10'd500;
		endcase
	endfunction
endpackage

// File: sdp_protect.sv
// short-circuit discharge protection with repeat-fault latch, AHB-Lite register slave
// assumes pin inputs are asynchronous to hclk; one AHB-Lite master, single word transfers
// What this block does
// - compare sense voltage to selected threshold level
// - short protection acts only when enabled
// - alert follows exceedance, clears at or below
// - fault only after exceedance lasts detection delay
// - trip clears alert, sets fault, discharge off
// - trip also requests charge off when configured
// - below threshold for recovery time clears fault
// - each trip increments latch counter, up to 15
// - counter decrements each quiet interval after recovery
// - nonzero counter raises latch and fail alerts unless latched
// - counter at limit sets latch fault, fail
// - latch protection acts only when enabled
// - latch recovery on load removal, charge, time
// - host recover command starts latch recovery
// - current recovery needs enable, series, charge on
// - current above threshold for whole recovery time
// - recovery means counter decrements per interval
// - latch fault clears below limit, releases switches
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
module sdp_protect
	import sdp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [9:0]  sense_diff_mv,
	input  wire logic [15:0] fast_current_reading,
	input  wire logic        load_removed,
	input  wire logic        charge_switch,
	output logic             short_alert,
	output logic             short_discharge_fault,
	output logic             latch_alert,
	output logic             permanent_fail_alert,
	output logic             repeat_short_latch,
	output logic             permanent_fail,
	output logic             discharge_switch_off_req,
	output logic             charge_switch_off_req
);
	sdp_pins_t   pins_meta_q, pins_s;
	logic [31:0] ctrl_q, time_q, latch_q, lrec_q, rdata_q;
	logic [7:0]  wr_addr_q;
	logic        wr_pend_q, cmd_q;
	logic        over_q, alert_q, fault_q, lfault_q, lrec_q_st, pf_q, dsg_q, chg_q;
	logic [3:0]  cnt_q;
	logic [10:0] tb_cnt_q;
	logic        tick;
	logic [15:0] det_cnt_q, rec_cnt_q, dec_cnt_q, ltime_cnt_q, lcur_cnt_q;
	logic [15:0] det_lim;
	logic [4:0]  dly_set;
	logic        trip, recover, dec_ev, ltrip, lclear, lstart, cur_ok;
	logic [9:0]  thr_level;

	// two-flop synchroniser for all pin inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_meta_q <= '0;
			pins_s      <= '0;
		end else begin
			pins_meta_q <= '{sense_diff_mv, fast_current_reading, load_removed, charge_switch};
			pins_s      <= pins_meta_q;
		end
	end

	// ahb-lite: zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// address phase capture; write data lands one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= hsel & htrans[1] & hready & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// writable registers; unmapped offsets are ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= CTRL_RST;
			time_q  <= TIME_RST;
			latch_q <= LATCH_RST;
			lrec_q  <= LREC_RST;
			cmd_q   <= 1'b0;
		end else begin
			cmd_q <= 1'b0;
			if (wr_pend_q) begin
				case (wr_addr_q)
					OFF_CTRL:  ctrl_q  <= hwdata;
					OFF_TIME:  time_q  <= hwdata;
					OFF_LATCH: latch_q <= hwdata;
					OFF_LREC:  lrec_q  <= hwdata;
					OFF_CMD:   cmd_q   <= (hwdata[15:0] == CMD_LATCH_RECOVER);
					default:   cmd_q   <= 1'b0;
				endcase
			end
		end
	end

	// read data is registered at the address phase so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (hsel & htrans[1] & hready & ~hwrite) begin
			case (haddr[7:0])
				OFF_CTRL:  rdata_q <= ctrl_q;
				OFF_TIME:  rdata_q <= time_q;
				OFF_LATCH: rdata_q <= latch_q;
				OFF_LREC:  rdata_q <= lrec_q;
				OFF_STAT:  rdata_q <= {6'h00, thr_level, 3'h0, lrec_q_st, cnt_q,
				                      chg_q, dsg_q, pf_q, lfault_q, permanent_fail_alert,
				                      latch_alert, fault_q, alert_q};
				default:   rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign hrdata = rdata_q;

	// threshold and delay decode
	assign thr_level = sdp_thr_mv(ctrl_q[F_THR +: 4]);
	assign dly_set   = (ctrl_q[F_DLY +: 5] > 5'(DLY_MAX)) ? 5'(DLY_MAX) : ctrl_q[F_DLY +: 5];
	assign det_lim   = 16'(32'(dly_set) * STEP_CYC);

	// 15 us timebase for the slow timers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tb_cnt_q <= 11'h000;
		end else if (tb_cnt_q == 11'(STEP_CYC - 1)) begin
			tb_cnt_q <= 11'h000;
		end else begin
			tb_cnt_q <= tb_cnt_q + 11'h001;
		end
	end
	assign tick = (tb_cnt_q == 11'(STEP_CYC - 1));

	// comparator, gated by the protection enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			over_q <= 1'b0;
		end else begin
			over_q <= ctrl_q[B_SCD_EN] & (pins_s.sense_mv > thr_level);
		end
	end

	// detection delay counts cycles of continuous exceedance
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			det_cnt_q <= 16'h0000;
		end else if (!over_q || fault_q) begin
			det_cnt_q <= 16'h0000;
		end else if (det_cnt_q != 16'hffff) begin
			det_cnt_q <= det_cnt_q + 16'h0001;
		end
	end
	// zero setting trips on the first sample over threshold
	assign trip = over_q & ~fault_q & (det_cnt_q >= det_lim);

	// alert tracks the comparator until the trip
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= over_q & ~fault_q & ~trip;
		end
	end

	// recovery timer, in 15 us ticks below threshold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_cnt_q <= 16'h0000;
		end else if (!fault_q || over_q) begin
			rec_cnt_q <= 16'h0000;
		end else if (tick && !recover) begin
			rec_cnt_q <= rec_cnt_q + 16'h0001;
		end
	end
	assign recover = fault_q & ~over_q & (rec_cnt_q >= time_q[15:0]);

	// fault status; a trip in the clearing cycle cannot happen since trip needs fault low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_q <= 1'b0;
		end else if (trip) begin
			fault_q <= 1'b1;
		end else if (recover) begin
			fault_q <= 1'b0;
		end
	end

	// decrement interval restarts on every trip, runs only while allowed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dec_cnt_q <= 16'h0000;
		end else if (trip || fault_q || cnt_q == 4'h0 || (lfault_q && !lrec_q_st)) begin
			dec_cnt_q <= 16'h0000;
		end else if (tick) begin
			dec_cnt_q <= dec_ev ? 16'h0000 : dec_cnt_q + 16'h0001;
		end
	end
	assign dec_ev = tick & ~trip & ~fault_q & (cnt_q != 4'h0) & (~lfault_q | lrec_q_st)
	                & (dec_cnt_q + 16'h0001 >= time_q[31:16]);

	// latch counter: trip wins over a decrement in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
		end else if (trip) begin
			if (cnt_q != CNT_MAX) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end else if (dec_ev) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end

	// latch trip and clear
	assign ltrip  = ctrl_q[B_LATCH_EN] & ~lfault_q & (cnt_q >= latch_q[3:0]);
	assign lclear = lfault_q & lrec_q_st & (cnt_q < latch_q[3:0]);

	// latch recovery time-based timer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ltime_cnt_q <= 16'h0000;
		end else if (!lfault_q || lrec_q_st) begin
			ltime_cnt_q <= 16'h0000;
		end else if (tick && ltime_cnt_q != 16'hffff) begin
			ltime_cnt_q <= ltime_cnt_q + 16'h0001;
		end
	end

	// current-based recovery needs the whole window above threshold
	assign cur_ok = ctrl_q[B_CUR_REC] & ctrl_q[B_SERIES] & pins_s.charge_switch
	                & ($signed(pins_s.current) >= $signed(lrec_q[15:0]));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lcur_cnt_q <= 16'h0000;
		end else if (!lfault_q || lrec_q_st || !cur_ok) begin
			lcur_cnt_q <= 16'h0000;
		end else if (tick && lcur_cnt_q != 16'hffff) begin
			lcur_cnt_q <= lcur_cnt_q + 16'h0001;
		end
	end

	// any recovery source starts the decrementing phase
	assign lstart = lfault_q & ~lrec_q_st &
	                ((ctrl_q[B_LD_EN] & pins_s.load_removed) |
	                 (cur_ok & (lcur_cnt_q >= lrec_q[31:16])) |
	                 (ltime_cnt_q >= latch_q[31:16]) |
	                 cmd_q);

	// latch fault, recovery phase and sticky permanent fail
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lfault_q  <= 1'b0;
			lrec_q_st <= 1'b0;
			pf_q      <= 1'b0;
		end else begin
			if (ltrip) begin
				lfault_q <= 1'b1;
				pf_q     <= 1'b1;
			end else if (lclear) begin
				lfault_q <= 1'b0;
			end
			if (lclear || !lfault_q) begin
				lrec_q_st <= 1'b0;
			end else if (lstart) begin
				lrec_q_st <= 1'b1;
			end
		end
	end

	// switch requests held while either fault stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dsg_q <= 1'b0;
			chg_q <= 1'b0;
		end else begin
			dsg_q <= ctrl_q[B_AUTO] & (fault_q | lfault_q);
			chg_q <= ctrl_q[B_CHG_CFG] & (fault_q | lfault_q);
		end
	end

	// latch alerts only while the counter is nonzero and the latch is not tripped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_alert          <= 1'b0;
			permanent_fail_alert <= 1'b0;
		end else begin
			latch_alert          <= ctrl_q[B_LATCH_EN] & (cnt_q != 4'h0) & ~lfault_q & ~ltrip;
			permanent_fail_alert <= ctrl_q[B_LATCH_EN] & (cnt_q != 4'h0) & ~lfault_q & ~ltrip;
		end
	end

	assign short_alert              = alert_q;
	assign short_discharge_fault    = fault_q;
	assign repeat_short_latch       = lfault_q;
	assign permanent_fail           = pf_q;
	assign discharge_switch_off_req = dsg_q;
	assign charge_switch_off_req    = chg_q;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_trip_then_auto;
		trip && ctrl_q[B_AUTO] ##1 fault_q;
	endsequence

	chk_alert_cause: assert property (alert_q |-> $past(over_q) && !fault_q)
		else $error("alert without exceedance");
	chk_trip_enabled: assert property (trip |-> $past(ctrl_q[B_SCD_EN]) && det_cnt_q >= det_lim)
		else $error("trip while disabled or early");
	chk_trip_fast: assert property (over_q && !fault_q && dly_set == 5'h0 |=> fault_q)
		else $error("fastest setting did not trip");
	chk_dsg_on_trip: assert property (s_trip_then_auto |=> dsg_q)
		else $error("discharge request missing");
	chk_chg_cfg: assert property (fault_q && ctrl_q[B_CHG_CFG] |=> chg_q)
		else $error("charge request missing");
	chk_count_up: assert property (trip && cnt_q != CNT_MAX |=> cnt_q == $past(cnt_q) + 4'h1)
		else $error("counter not incremented");
	chk_pf_alert_zero: assert property (cnt_q == 4'h0 ##1 cnt_q == 4'h0 |=> !permanent_fail_alert)
		else $error("fail alert with zero counter");
	chk_latch_trip: assert property (ltrip |=> lfault_q && pf_q ##1 !latch_alert)
		else $error("latch trip not taken");
	chk_cmd_recover: assert property (cmd_q && lfault_q && !lrec_q_st |=> lrec_q_st || !lfault_q)
		else $error("recover command ignored");
	chk_latch_clear: assert property (lclear |=> !lfault_q ##1 (dsg_q == ($past(ctrl_q[B_AUTO]) && $past(fault_q))))
		else $error("latch fault not released");
	chk_recover_time: assert property ($fell(fault_q) |-> !$past(over_q))
		else $error("fault cleared while over");
endmodule

// File: sdp_pack_model.sv
// pack-side model: sense comparator input, current reading, load detect and charge switch
// assumes the bench sets the wanted levels; the model registers them on hclk like real pins
module sdp_pack_model
	import sdp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [9:0]  sense_set,
	input  wire logic [15:0] current_set,
	input  wire logic        load_gone_set,
	input  wire logic        charge_switch_off_req,
	output logic      [9:0]  sense_diff_mv,
	output logic      [15:0] fast_current_reading,
	output logic             load_removed,
	output logic             charge_switch
);
	timeunit 1ns;
	timeprecision 1ps;

	sdp_pins_t pins_q;

	// charge switch follows the off request one edge late, as a real switch would lag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_q <= '0;
		end else begin
			pins_q.sense_mv      <= sense_set;
			pins_q.current       <= current_set;
			pins_q.load_removed  <= load_gone_set;
			pins_q.charge_switch <= !charge_switch_off_req;
		end
	end

	// pin group out to the block
	assign sense_diff_mv        = pins_q.sense_mv;
	assign fast_current_reading = pins_q.current;
	assign load_removed         = pins_q.load_removed;
	assign charge_switch        = pins_q.charge_switch;
endmodule

// File: tb_sdp_protect.sv
// self-checking bench for the short-circuit protection block
// assumes the AHB slave is the only one on the bus, so hready is its own hreadyout
module tb_sdp_protect;
	import sdp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        hclk, hresetn, hsel, hwrite, load_set;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [9:0]  sense_set, sense_diff_mv;
	logic [15:0] current_set, fast_current_reading;
	logic        hready, hreadyout, hresp, load_removed, charge_switch;
	logic        short_alert, short_discharge_fault, latch_alert, permanent_fail_alert;
	logic        repeat_short_latch, permanent_fail, discharge_switch_off_req, charge_switch_off_req;
	int          failures, samples_checked, n;
	localparam logic [9:0] thr_tab [16] = '{10, 20, 40, 60, 80, 100, 125, 150,
		175, 200, 250, 300, 350, 400, 450, 500};

	assign hready = hreadyout;
	always #5 hclk = !hclk;

	sdp_protect i_sdp_protect (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sense_diff_mv(sense_diff_mv),
		.fast_current_reading(fast_current_reading), .load_removed(load_removed),
		.charge_switch(charge_switch), .short_alert(short_alert), .short_discharge_fault(short_discharge_fault),
		.latch_alert(latch_alert), .permanent_fail_alert(permanent_fail_alert),
		.repeat_short_latch(repeat_short_latch), .permanent_fail(permanent_fail),
		.discharge_switch_off_req(discharge_switch_off_req), .charge_switch_off_req(charge_switch_off_req));

	sdp_pack_model i_sdp_pack_model (.hclk(hclk), .hresetn(hresetn), .sense_set(sense_set),
		.current_set(current_set), .load_gone_set(load_set), .charge_switch_off_req(charge_switch_off_req),
		.sense_diff_mv(sense_diff_mv), .fast_current_reading(fast_current_reading),
		.load_removed(load_removed), .charge_switch(charge_switch));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic end_of_test();
		if (failures == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// address phase held until hready, then data phase held until hready again
	task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h0000_0000, "error response");
	endtask

	task automatic reset_dut();
		hresetn <= 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask

	// reset values, read-only status, unmapped place and write-only command
	task automatic reg_scenario();
		ahb_xfer(0, OFF_CTRL, 32'h0);
		chk(rd, CTRL_RST, "ctrl reset");
		ahb_xfer(0, OFF_TIME, 32'h0);
		chk(rd, TIME_RST, "time reset");
		ahb_xfer(0, OFF_LATCH, 32'h0);
		chk(rd, LATCH_RST, "latch reset");
		ahb_xfer(0, OFF_LREC, 32'h0);
		chk(rd, LREC_RST, "lrec reset");
		ahb_xfer(1, OFF_STAT, 32'hffffffff);
		ahb_xfer(0, OFF_STAT, 32'h0);
		chk(rd, 32'h000a0000, "stat reset or written");
		ahb_xfer(0, OFF_CMD, 32'h0);
		chk(rd, 32'h0, "cmd reads zero");
		ahb_xfer(1, 8'h20, 32'h12345678);
		ahb_xfer(0, 8'h20, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		ahb_xfer(1, OFF_TIME, 32'h00040001);
		ahb_xfer(0, OFF_TIME, 32'h0);
		chk(rd, 32'h00040001, "time readback");
	endtask

	// every threshold index shows its level in the status field
	task automatic thr_scenario();
		for (int i = 0; i < 16; i++) begin
			ahb_xfer(1, OFF_CTRL, 32'(i) << F_THR);
			ahb_xfer(0, OFF_STAT, 32'h0);
			chk(32'(rd[25:16]), 32'(thr_tab[i]), "threshold level");
		end
	endtask

	// protection disabled: even a hard short raises nothing
	task automatic off_scenario();
		ahb_xfer(1, OFF_CTRL, 32'h00000400);
		sense_set <= 10'd300;
		repeat (40) @(posedge hclk);
		chk(short_alert, 1'h0, "alert while disabled");
		chk(short_discharge_fault, 1'h0, "fault while disabled");
		sense_set <= 10'd0;
		repeat (10) @(posedge hclk);
	endtask

	// boundary, delay of two steps, trip actions, recovery and counter decrement
	task automatic trip_scenario();
		ahb_xfer(1, OFF_CTRL, 32'h0002040f);
		sense_set <= 10'd80;
		repeat (20) @(posedge hclk);
		chk(short_alert, 1'h0, "alert at threshold");
		sense_set <= 10'd81;
		for (n = 0; n < 8 && short_alert !== 1'b1; n++) @(posedge hclk);
		chk(short_alert, 1'h1, "alert above threshold");
		repeat (2900) @(posedge hclk);
		chk(short_discharge_fault, 1'h0, "fault before delay");
		for (n = 0; n < 200 && short_discharge_fault !== 1'b1; n++) @(posedge hclk);
		chk(short_discharge_fault, 1'h1, "fault after delay");
		repeat (2) @(posedge hclk);
		chk(short_alert, 1'h0, "alert cleared on trip");
		chk(discharge_switch_off_req, 1'h1, "discharge off");
		chk(charge_switch_off_req, 1'h1, "charge off");
		chk({latch_alert, permanent_fail_alert}, 2'h3, "latch alerts");
		ahb_xfer(0, OFF_STAT, 32'h0);
		chk(32'(rd[11:8]), 32'h1, "counter after trip");
		sense_set <= 10'd0;
		for (n = 0; n < 4600 && short_discharge_fault !== 1'b0; n++) @(posedge hclk);
		repeat (2) @(posedge hclk);
		chk({short_discharge_fault, discharge_switch_off_req, charge_switch_off_req}, 3'h0, "recovery");
		repeat (3000) @(posedge hclk);
		chk(latch_alert, 1'h1, "counter held early");
		for (n = 0; n < 6000 && latch_alert !== 1'b0; n++) @(posedge hclk);
		chk({latch_alert, permanent_fail_alert}, 2'h0, "counter decremented");
	endtask

	// fastest delay: trip then let the fault recover
	task automatic fast_trip();
		sense_set <= 10'd100;
		for (n = 0; n < 12 && short_discharge_fault !== 1'b1; n++) @(posedge hclk);
		chk(short_discharge_fault, 1'h1, "fast trip");
		sense_set <= 10'd0;
		for (n = 0; n < 4600 && short_discharge_fault !== 1'b0; n++) @(posedge hclk);
	endtask

	// latch at limit two, then leave it by command, load, current or time
	task automatic latch_scenario(input int m);
		reset_dut();
		ahb_xfer(1, OFF_TIME, 32'h00040001);
		ahb_xfer(1, OFF_LATCH, (m == 3) ? 32'h00020002 : 32'h0fff0002);
		ahb_xfer(1, OFF_LREC, 32'h0001fff6);
		ahb_xfer(1, OFF_CTRL, 32'h00000007 | ((m == 1) ? 32'h20 : 32'h0) | ((m == 2) ? 32'h50 : 32'h0));
		// current mode starts below the -10 threshold so recovery must wait for it
		if (m == 2) current_set <= 16'hffec;
		fast_trip();
		fast_trip();
		repeat (4) @(posedge hclk);
		chk({repeat_short_latch, permanent_fail}, 2'h3, "latch trip");
		chk({latch_alert, permanent_fail_alert}, 2'h0, "alerts off at trip");
		chk({discharge_switch_off_req, charge_switch_off_req}, 2'h2, "latch switch off");
		if (m == 0 || m == 2) begin
			repeat (7600) @(posedge hclk);
			ahb_xfer(0, OFF_STAT, 32'h0);
			chk(32'(rd[11:8]), 32'h2, "no decrement while latched");
			chk(32'(rd[S_LREC]), 32'h0, "recovery begun early");
			if (m == 0) ahb_xfer(1, OFF_CMD, 32'(CMD_LATCH_RECOVER));
			else current_set <= 16'h0000;
		end
		if (m == 1) load_set <= 1'b1;
		for (n = 0; n < 12000 && repeat_short_latch !== 1'b0; n++) @(posedge hclk);
		repeat (2) @(posedge hclk);
		chk({repeat_short_latch, discharge_switch_off_req}, 2'h0, "latch released");
		chk(permanent_fail, 1'h1, "fail stays");
		ahb_xfer(0, OFF_STAT, 32'h0);
		chk(32'(rd[11:8]), 32'h1, "counter below limit");
		load_set <= 1'b0;
	endtask

	// hang guard, above the expected run length of about 65000 cycles
	initial begin
		repeat (90000) @(posedge hclk);
		failures++;
		end_of_test();
	end

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sense_set = 10'h000;
		current_set = 16'h0000;
		load_set = 1'b0;
		failures = 0;
		samples_checked = 0;
		reset_dut();
		reg_scenario();
		thr_scenario();
		off_scenario();
		trip_scenario();
		for (int m = 0; m < 4; m++) latch_scenario(m);
		end_of_test();
	end
endmodule
